// *** design/intc_regs_defines.svh ***
// Offsets, field positions and reset values of the extended-mode registers.
`ifndef INTC_REGS_DEFINES_SVH
`define INTC_REGS_DEFINES_SVH
`define OFS_TOPO_ID        12'h0802
`define OFS_MEMBER_BITMASK     12'h080D
`define OFS_INT_CMD        12'h0830
`define OFS_SELF_INT       12'h083F
`define BROADCAST_ID       32'hFFFF_FFFF
`define CMD_VECTOR_LSB     0
`define CMD_TYPE_LSB       8
`define CMD_DSTMODE_BIT    11
`define CMD_DELIV_BIT      12
`define CMD_TRIG_BIT       15
`define CMD_RRS_LSB        16
`define CMD_SHORT_LSB      18
`define CMD_TARGET_IDENTIFIER_LSB       32
`define CMD_RSVD_MASK      64'h0000_0000_FFF3_3000
`define SELF_RSVD_MASK     64'hFFFF_FFFF_FFFF_FF00
`define SHORT_SELF         2'h1
`define TYPE_FIXED         3'h0
`define ID_MEMBER_LSB      0
`define ID_GROUP_LSB       4
`define TOPO_ID_RESET      32'h0000_0000
`endif

// *** design/intc_regs_pkg.sv ***
// Types shared by the extended-mode register block.
package intc_regs_pkg;
  typedef enum logic [1:0] {
    MODE_DISABLED,
    MODE_LEGACY,
    MODE_EXTENDED
  } intc_mode_t;
  typedef enum {
    ST_IDLE,
    ST_DONE
  } acc_state_t;
endpackage

// *** design/local_intc_id_ipi_regs.sv ***
// Extended-mode identifier, command, logical destination and self registers.
//
// Behaviour
// R1: Expose 32-bit topology identifier from reset.
// R2: Identifier is concatenated topology sub-fields.
// R3: Identifier read returns it in low bits.
// R4: Identifier write or non-extended read faults.
// R5: Topology query reports identifier in every mode.
// R6: Extended query: 32-bit, 8-bit legacy, zero disabled.
// R7: One 64-bit write sends an interrupt.
// R8: Command bits 63:32 hold destination.
// R9: All-ones destination broadcasts to everyone.
// R10: Software writes zero to bits 17:16.
// R11: Message types 1, 3, 7 reserved.
// R12: Software writes zero to bit 12.
// R13: Logical destination read-only, loaded on enable.
// R14: Upper half group, lower half member mask.
// R15: Logical match: group equal, mask overlaps.
// R16: No flat logical addressing in extended mode.
// R17: Mask is one-hot of id[3:0]; group id[19:4].
// R18: Self register write-only; read faults.
// R19: Self vector in 7:0; upper bits zero.
// R20: Self write equals fixed edge self command.
// R21: Self interrupt handled like command self.
// R22: Pending set, trigger bit clear on completion.
// R23: Reserved bit written one faults.
// R24: Reserved bits read as zero.
// R25: Valid command write issues one message.
`timescale 1ns/1ps
`default_nettype none
`include "intc_regs_defines.svh"
module local_intc_id_ipi_regs
  import intc_regs_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic [31:0] topo_strap,
  input  wire logic [1:0]  mode_sel,
  input  wire logic        model_reg_read,
  input  wire logic        model_reg_write,
  input  wire logic [11:0] reg_addr,
  input  wire logic [63:0] reg_wdata,
  input  wire logic        msg_in_valid,
  input  wire logic [31:0] msg_in_target,
  input  wire logic        msg_in_logical,
  output logic             acc_done,
  output logic [63:0]      reg_rdata,
  output logic             general_protection_fault,
  output logic [31:0]      topo_query_id,
  output logic [31:0]      ext_query_id,
  output logic [31:0]      logical_destination,
  output logic             msg_out_valid,
  output logic [7:0]       msg_out_vector,
  output logic [2:0]       msg_out_type,
  output logic             msg_out_logical,
  output logic             msg_out_trigger,
  output logic [1:0]       msg_out_shorthand,
  output logic [31:0]      msg_out_target,
  output logic             msg_out_broadcast,
  output logic             msg_in_accept,
  output logic             self_pending_set,
  output logic [7:0]       self_pending_vector,
  output logic             self_trigger_clear
);

  //////////////////////////////////////////////////////////////////////////
  // Identifier capture and mode.

  logic [31:0] topology_identifier_reg;
  logic        id_loaded_reg;
  logic [31:0] interrupt_command_lo_reg;
  logic [31:0] target_identifier_reg;
  logic        ext_prev_reg;
  intc_mode_t  mode;
  logic        extended_intc_mode;
  logic        legacy_intc_mode;

  assign mode = (mode_sel == 2'h2) ? MODE_EXTENDED :
                (mode_sel == 2'h1) ? MODE_LEGACY : MODE_DISABLED;
  assign extended_intc_mode = (mode == MODE_EXTENDED);
  assign legacy_intc_mode   = (mode == MODE_LEGACY);

  // The strap is caught by a clocked process once after reset release, so
  // the reset branch loads only TOPO_ID_RESET and never samples a port.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      topology_identifier_reg <= `TOPO_ID_RESET;
      id_loaded_reg           <= 1'b0;
    end else if (!id_loaded_reg) begin
      topology_identifier_reg <= topo_strap; // R1 R2
      id_loaded_reg           <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Logical destination derivation and incoming match.

  logic [15:0] group_number;
  logic [15:0] member_bitmask;
  logic [31:0] logical_next;
  logic        group_hit;
  logic        member_hit;
  logic        phys_hit;
  logic        accept_next;

  assign group_number   = topology_identifier_reg[19:`ID_GROUP_LSB]; // R17
  assign member_bitmask = 16'h0001 << topology_identifier_reg[3:0]; // R17
  assign logical_next   = {group_number, member_bitmask}; // R14
  assign group_hit  = (msg_in_target[31:16] == logical_destination[31:16]);
  assign member_hit = |(msg_in_target[15:0] & logical_destination[15:0]);
  assign phys_hit   = (msg_in_target == topology_identifier_reg) ||
                      (msg_in_target == `BROADCAST_ID); // R9
  // Only cluster matching is offered; the flat model is never decoded.
  assign accept_next = msg_in_valid && extended_intc_mode &&
                       (msg_in_logical ? (group_hit && member_hit) // R15 R16
                                       : phys_hit);

  //////////////////////////////////////////////////////////////////////////
  // Access decode and fault checks.

  logic hit_id;
  logic hit_logical;
  logic hit_cmd;
  logic hit_self;
  logic any_access;
  logic fault_next;
  logic cmd_type_bad;
  logic cmd_ok;
  logic self_ok;
  logic [63:0] rdata_next;

  assign hit_id      = (reg_addr == `OFS_TOPO_ID);
  assign hit_logical = (reg_addr == `OFS_MEMBER_BITMASK);
  assign hit_cmd     = (reg_addr == `OFS_INT_CMD);
  assign hit_self    = (reg_addr == `OFS_SELF_INT);
  assign any_access = model_reg_read || model_reg_write;
  assign cmd_type_bad = (reg_wdata[10:8] == 3'h1) ||
                        (reg_wdata[10:8] == 3'h3) ||
                        (reg_wdata[10:8] == 3'h7); // R11
  // Reserved mask covers 17:16 and 12 so a careless write cannot slip by.
  assign cmd_ok  = model_reg_write && hit_cmd && extended_intc_mode &&
                   !cmd_type_bad &&
                   ((reg_wdata & `CMD_RSVD_MASK) == 64'h0000_0000_0000_0000);
  assign self_ok = model_reg_write && hit_self && extended_intc_mode &&
                   ((reg_wdata & `SELF_RSVD_MASK) ==
                    64'h0000_0000_0000_0000); // R19 R23
  assign fault_next = any_access && (
      !extended_intc_mode ||                              // R4
      (model_reg_write && (hit_id || hit_logical)) ||     // R4 R13
      (model_reg_read && hit_self) ||                     // R18
      (model_reg_write && hit_cmd && !cmd_ok) ||          // R10 R12 R23
      (model_reg_write && hit_self && !self_ok) ||        // R23
      !(hit_id || hit_logical || hit_cmd || hit_self));
  assign rdata_next =
      (!model_reg_read || fault_next) ? 64'h0000_0000_0000_0000 :
      hit_id  ? {32'h0000_0000, topology_identifier_reg} :    // R3 R24
      hit_logical ? {32'h0000_0000, logical_destination} :    // R24
      {target_identifier_reg, interrupt_command_lo_reg};

  //////////////////////////////////////////////////////////////////////////
  // Registers.

  always_ff @(posedge clk) begin
    if (!rstn) begin
      interrupt_command_lo_reg <= 32'h0000_0000;
      target_identifier_reg    <= 32'h0000_0000;
      logical_destination      <= 32'h0000_0000;
      ext_prev_reg             <= 1'b0;
    end else begin
      ext_prev_reg <= extended_intc_mode;
      if (extended_intc_mode && !ext_prev_reg) begin
        logical_destination <= logical_next; // R13
      end
      if (cmd_ok) begin
        interrupt_command_lo_reg <= reg_wdata[31:0];
        target_identifier_reg    <= reg_wdata[63:32]; // R8
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      acc_done                 <= 1'b0;
      reg_rdata                <= 64'h0000_0000_0000_0000;
      general_protection_fault <= 1'b0;
      topo_query_id            <= 32'h0000_0000;
      ext_query_id             <= 32'h0000_0000;
      msg_in_accept            <= 1'b0;
    end else begin
      acc_done                 <= any_access;
      reg_rdata                <= rdata_next;
      general_protection_fault <= fault_next;
      topo_query_id            <= topology_identifier_reg; // R5
      ext_query_id <= extended_intc_mode ? topology_identifier_reg :
                      legacy_intc_mode ?
                      {24'h00_0000, topology_identifier_reg[7:0]} :
                      32'h0000_0000; // R6
      msg_in_accept <= accept_next; // R15
    end
  end

  // Outgoing message and self delivery. The pending set goes out in the same
  // edge as acc_done, so the write is never seen complete before it lands.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      msg_out_valid       <= 1'b0;
      msg_out_vector      <= 8'h00;
      msg_out_type        <= 3'h0;
      msg_out_logical     <= 1'b0;
      msg_out_trigger     <= 1'b0;
      msg_out_shorthand   <= 2'h0;
      msg_out_target      <= 32'h0000_0000;
      msg_out_broadcast   <= 1'b0;
      self_pending_set    <= 1'b0;
      self_pending_vector <= 8'h00;
      self_trigger_clear  <= 1'b0;
    end else begin
      msg_out_valid <= cmd_ok && (reg_wdata[19:18] != `SHORT_SELF); // R7 R25
      msg_out_vector    <= reg_wdata[7:0];
      msg_out_type      <= reg_wdata[10:8];
      msg_out_logical   <= reg_wdata[`CMD_DSTMODE_BIT];
      msg_out_trigger   <= reg_wdata[`CMD_TRIG_BIT];
      msg_out_shorthand <= reg_wdata[19:18];
      msg_out_target    <= reg_wdata[63:32]; // R8
      msg_out_broadcast <= (reg_wdata[63:32] == `BROADCAST_ID); // R9
      // Both paths to self share one delivery strobe.
      self_pending_set <= self_ok ||
        (cmd_ok && reg_wdata[19:18] == `SHORT_SELF); // R20 R21 R22
      self_pending_vector <= reg_wdata[7:0]; // R19
      self_trigger_clear  <= self_ok ||
        (cmd_ok && reg_wdata[19:18] == `SHORT_SELF &&
         !reg_wdata[`CMD_TRIG_BIT]); // R22
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Assertions.

  property p_id_write_faults;
    @(posedge clk) disable iff (!rstn)
      model_reg_write && hit_id |=> general_protection_fault && acc_done;
  endproperty
  a_id_write_faults: assert property (p_id_write_faults) // R4
    else $error("identifier write did not fault");

  property p_self_read_faults;
    @(posedge clk) disable iff (!rstn)
      model_reg_read && hit_self |=> general_protection_fault &&
        reg_rdata == 64'h0000_0000_0000_0000;
  endproperty
  a_self_read_faults: assert property (p_self_read_faults) // R18
    else $error("self register read did not fault");

  property p_id_read;
    @(posedge clk) disable iff (!rstn)
      model_reg_read && hit_id && extended_intc_mode |=>
        reg_rdata == {32'h0000_0000, $past(topology_identifier_reg)};
  endproperty
  a_id_read: assert property (p_id_read) // R3
    else $error("identifier read returned wrong data");

  property p_self_pending;
    @(posedge clk) disable iff (!rstn)
      self_ok |=> self_pending_set && self_trigger_clear &&
        self_pending_vector == $past(reg_wdata[7:0]) && acc_done;
  endproperty
  a_self_pending: assert property (p_self_pending) // R22
    else $error("self write not recorded as pending");

  property p_cmd_sends;
    @(posedge clk) disable iff (!rstn)
      cmd_ok && reg_wdata[19:18] == 2'h0 |=>
        msg_out_valid ##1 (!msg_out_valid || $past(cmd_ok));
  endproperty
  a_cmd_sends: assert property (p_cmd_sends) // R25
    else $error("command write did not send one message");

  property p_reserved_type;
    @(posedge clk) disable iff (!rstn)
      model_reg_write && hit_cmd && cmd_type_bad |=>
        general_protection_fault && !msg_out_valid;
  endproperty
  a_reserved_type: assert property (p_reserved_type) // R11
    else $error("reserved message type accepted");

  property p_ext_query;
    @(posedge clk) disable iff (!rstn)
      !extended_intc_mode && !legacy_intc_mode |=>
        ext_query_id == 32'h0000_0000;
  endproperty
  a_ext_query: assert property (p_ext_query) // R6
    else $error("extended query not zero while disabled");

  property p_logical_load;
    @(posedge clk) disable iff (!rstn)
      extended_intc_mode && !ext_prev_reg |=>
        logical_destination[15:0] ==
          (16'h0001 << $past(topology_identifier_reg[3:0])) &&
        logical_destination[31:16] == $past(topology_identifier_reg[19:4]);
  endproperty
  a_logical_load: assert property (p_logical_load) // R13
    else $error("logical destination not loaded on enable");

  property p_broadcast;
    @(posedge clk) disable iff (!rstn)
      cmd_ok && reg_wdata[63:32] == 32'hFFFF_FFFF |=> msg_out_broadcast;
  endproperty
  a_broadcast: assert property (p_broadcast) // R9
    else $error("all-ones target not flagged as broadcast");

endmodule // local_intc_id_ipi_regs
`default_nettype wire

// *** sim/peer_intc.sv ***
// Model of the other interrupt controllers on the message side.
`timescale 1ns/1ps
`default_nettype none
module peer_intc (
  input  wire logic        clk,
  input  wire logic        msg_out_valid,
  input  wire logic [31:0] msg_out_target,
  output logic             msg_in_valid,
  output logic [31:0]      msg_in_target,
  output logic             msg_in_logical
);
  int          n_rx;
  logic [31:0] rx_target;
  initial begin
    msg_in_valid   = 1'b0;
    msg_in_target  = 32'h0000_0000;
    msg_in_logical = 1'b0;
    n_rx           = 0;
  end
  // Every issued message lands here once; the bench checks the count.
  always @(posedge clk) begin
    if (msg_out_valid === 1'b1) begin
      n_rx      <= n_rx + 1;
      rx_target <= msg_out_target;
    end
  end
  // A message stands for one cycle; afterwards the lines carry the inverse
  // so that a stale target can never pass for a fresh one.
  task automatic send(input logic [31:0] target, input logic logical);
    @(posedge clk);
    msg_in_valid   <= 1'b1;
    msg_in_target  <= target;
    msg_in_logical <= logical;
    @(posedge clk);
    msg_in_valid   <= 1'b0;
    msg_in_target  <= ~target;
    msg_in_logical <= ~logical;
  endtask
endmodule // peer_intc
`default_nettype wire

// *** sim/tb_top.sv ***
// Self-checking bench for the extended-mode register block.
`timescale 1ns/1ps
`default_nettype none
`include "intc_regs_defines.svh"
module tb_top;
  import intc_regs_pkg::*;
  localparam logic [31:0] STRAP = 32'h0012_3456;
  localparam logic [31:0] LOGICAL_EXP = 32'h2345_0040;
  logic        clk, rstn, model_reg_read, model_reg_write;
  logic        msg_in_valid, msg_in_logical, acc_done, msg_out_valid;
  logic        general_protection_fault, msg_out_logical, msg_out_trigger;
  logic        msg_out_broadcast, msg_in_accept, self_pending_set;
  logic        self_trigger_clear;
  logic [1:0]  mode_sel, msg_out_shorthand;
  logic [2:0]  msg_out_type;
  logic [7:0]  msg_out_vector, self_pending_vector;
  logic [11:0] reg_addr;
  logic [31:0] topo_strap, msg_in_target, topo_query_id, ext_query_id;
  logic [31:0] logical_destination, msg_out_target;
  logic [63:0] reg_wdata, reg_rdata;
  int          n_mismatch, num_checks, cyc;
  local_intc_id_ipi_regs DUT (.clk, .rstn, .topo_strap, .mode_sel,
    .model_reg_read, .model_reg_write, .reg_addr, .reg_wdata, .msg_in_valid,
    .msg_in_target, .msg_in_logical, .acc_done, .reg_rdata,
    .general_protection_fault, .topo_query_id, .ext_query_id,
    .logical_destination, .msg_out_valid, .msg_out_vector, .msg_out_type,
    .msg_out_logical, .msg_out_trigger, .msg_out_shorthand, .msg_out_target,
    .msg_out_broadcast, .msg_in_accept, .self_pending_set,
    .self_pending_vector, .self_trigger_clear);
  peer_intc peer (.clk, .msg_out_valid, .msg_out_target, .msg_in_valid,
    .msg_in_target, .msg_in_logical);
  ////////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // The answer stands for one cycle only, so it is judged right here.
  task automatic acc(input logic w, input logic [11:0] a,
                     input logic [63:0] d, input logic f);
    @(posedge clk);
    model_reg_read  <= ~w;
    model_reg_write <= w;
    reg_addr        <= a;
    reg_wdata       <= d;
    @(posedge clk);
    model_reg_read  <= 1'b0;
    model_reg_write <= 1'b0;
    #1;
    chk(acc_done, 1);
    chk(general_protection_fault, f);
  endtask
  task automatic set_mode(input logic [1:0] m);
    @(posedge clk);
    mode_sel <= m;
    repeat (3) @(posedge clk);
    #1;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_modes();
    chk(topo_query_id, STRAP);
    chk(ext_query_id, 0);
    set_mode(MODE_LEGACY);
    chk(ext_query_id, 32'h0000_0056);
    acc(0, `OFS_TOPO_ID, 0, 1);
    set_mode(MODE_EXTENDED);
    chk(ext_query_id, STRAP);
    chk(logical_destination, LOGICAL_EXP);
    acc(0, `OFS_TOPO_ID, 0, 0);
    chk(reg_rdata, {32'h0000_0000, STRAP});
    acc(1, `OFS_TOPO_ID, 0, 1);
    acc(1, `OFS_MEMBER_BITMASK, 0, 1);
    acc(0, `OFS_MEMBER_BITMASK, 0, 0);
    chk(reg_rdata, {32'h0000_0000, LOGICAL_EXP});
    acc(0, `OFS_SELF_INT, 0, 1);
    acc(0, 12'h0803, 0, 1);
    $display("test modes done");
  endtask
  task automatic t_cmd();
    logic [31:0] bad [6];
    bad = '{32'h0000_0100, 32'h0000_0300, 32'h0000_0700, 32'h0000_1000,
            32'h0001_0000, 32'h0010_0000};
    acc(1, `OFS_INT_CMD, 64'h0000_0077_0000_8A41, 0);
    chk({msg_out_valid, msg_out_logical, msg_out_trigger}, 3'h7);
    chk({msg_out_vector, msg_out_type, msg_out_shorthand}, 13'h0828);
    chk({msg_out_target, msg_out_broadcast}, 33'h0_0000_00EE);
    acc(1, `OFS_INT_CMD, 64'hFFFF_FFFF_0000_0030, 0);
    chk({msg_out_valid, msg_out_broadcast}, 2'h3);
    for (int i = 0; i < 6; i++) begin
      acc(1, `OFS_INT_CMD, {32'h0000_0001, bad[i]}, 1);
      chk(msg_out_valid, 0);
    end
    acc(0, `OFS_INT_CMD, 0, 0);
    chk(reg_rdata, 64'hFFFF_FFFF_0000_0030);
    acc(1, `OFS_INT_CMD, 64'h0000_0000_0004_0052, 0);
    chk({msg_out_valid, self_pending_set, self_trigger_clear}, 3'h3);
    chk(self_pending_vector, 8'h52);
    @(posedge clk);
    #1;
    chk(peer.n_rx, 2);
    chk(peer.rx_target, 32'hFFFF_FFFF);
    $display("test command done");
  endtask
  task automatic t_self();
    acc(1, `OFS_SELF_INT, 64'h0000_0000_0000_00A5, 0);
    chk({self_pending_set, self_trigger_clear}, 2'h3);
    chk(self_pending_vector, 8'hA5);
    acc(1, `OFS_SELF_INT, 64'h0000_0000_0000_01A5, 1);
    chk(self_pending_set, 0);
    $display("test self done");
  endtask
  task automatic t_msg();
    logic [31:0] tg [7];
    logic [6:0]  lg;
    logic [6:0]  ok;
    tg = '{32'h2345_0041, 32'h2345_0080, 32'h2346_0040, 32'h0000_00FF,
           STRAP, 32'hFFFF_FFFF, 32'h0012_3457};
    lg = 7'b1111000;
    ok = 7'b1000110;
    for (int i = 0; i < 7; i++) begin
      peer.send(tg[i], lg[6 - i]);
      #1;
      chk(msg_in_accept, ok[6 - i]);
    end
    set_mode(MODE_LEGACY);
    peer.send(32'h2345_0040, 1'b1);
    #1;
    chk(msg_in_accept, 0);
    // Code 3 is the second way to say disabled.
    set_mode(2'h3);
    chk(ext_query_id, 0);
    chk(topo_query_id, STRAP);
    $display("test message done");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Whole run needs about a hundred cycles; this ceiling catches a hang.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      test_done();
    end
  end
  initial begin
    {rstn, model_reg_read, model_reg_write, mode_sel} = 0;
    {reg_addr, reg_wdata, cyc, n_mismatch, num_checks} = 0;
    topo_strap = STRAP;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    t_modes();
    t_cmd();
    t_self();
    t_msg();
    test_done();
  end
endmodule // tb_top
`default_nettype wire
